// ===== core/ident_map.svh
/*
 * Word addresses, fixed field values and sizes of the identify parameter block.
 * Assumes it is included by its bare name from the package and the design modules.
 */
// Overview of operation
// R1: Block goes to the host by the same protocol as a sector read.
// R2: Reserved bits and reserved words of the block read zero.
// R3: Word 0 gives default value in PCMCIA, alternate with bit 6 in IDE.
// R4: Word 1 gives default translated cylinders, equal to the cylinder count.
// R5: Words 7-8 hold sector count, which is also first invalid LBA.
// R6: Serial text, words 10-19, right justified and padded with spaces.
// R7: Model text, words 27-46, left justified and padded with spaces.
// R8: Word 47 gives most sectors per interrupt for multiple commands.
// R9: Word 49: bit 13 zero, bit 9 LBA support, bit 8 DMA support.
// R10: Word 51 upper byte reads 02h, highest original PIO mode.
// R11: Word 53 bit 1 validates words 64-70, bit 0 words 54-58.
// R12: Words 57-58 hold product of current cylinders, heads and sectors.
// R13: Word 59: bits 15-9 zero, bit 8 one, low byte 00h or 01h.
// R14: Word 63 upper byte is one-hot selected DMA mode, bits 15-11 zero.
// R15: Word 63 lower byte flags supported DMA modes, bits 7-3 zero.
// R16: Word 64 bit 1 PIO mode 4, bit 0 PIO mode 3, rest zero.
// R17: Words 65 to 68 each return 50h cycle time; the code returns zero in words 65-66 in PCMCIA mode.
// R18: Word 163 bits 2-0 and 5-3 return 2h.
// R19: Word 163 bits 8-6 selected PIO mode, bits 11-9 selected DMA mode.
// R20: Word 47 holds 0001h.
// R21: Word 63 reads 0407h by default, zero in PCMCIA mode.
// R22: 256 sixteen-bit words, one sector, sent in ascending word order.
`ifndef IDENT_MAP_SVH
`define IDENT_MAP_SVH

`define ID_WORDS        256
`define ID_LAST_WORD    8'hff
`define ID_W_CFG        8'h00
`define ID_W_DEF_CYL    8'h01
`define ID_W_DEF_HEAD   8'h03
`define ID_W_DEF_SPT    8'h06
`define ID_W_CAP_MSW    8'h07
`define ID_W_CAP_LSW    8'h08
`define ID_W_SER_FIRST  8'h0a
`define ID_W_SER_LAST   8'h13
`define ID_W_RSV22      8'h16
`define ID_W_FW_FIRST   8'h17
`define ID_W_FW_LAST    8'h1a
`define ID_W_MOD_FIRST  8'h1b
`define ID_W_MOD_LAST   8'h2e
`define ID_W_MULT_MAX   8'h2f
`define ID_W_CAPS       8'h31
`define ID_W_PIO_OLD    8'h33
`define ID_W_VALID      8'h35
`define ID_W_CUR_CYL    8'h36
`define ID_W_CUR_HEAD   8'h37
`define ID_W_CUR_SPT    8'h38
`define ID_W_CUR_LSW    8'h39
`define ID_W_CUR_MSW    8'h3a
`define ID_W_MULT_SET   8'h3b
`define ID_W_LBA_LSW    8'h3c
`define ID_W_LBA_MSW    8'h3d
`define ID_W_DMA        8'h3f
`define ID_W_PIO_ADV    8'h40
`define ID_W_DMA_MIN    8'h41
`define ID_W_DMA_REC    8'h42
`define ID_W_PIO_MIN    8'h43
`define ID_W_PIO_IORDY  8'h44
`define ID_W_ADV_IDE    8'ha3
`define ID_W_ADV_PCM    8'ha4

`define ID_RSV22_VAL    16'h0004
`define ID_MULT_MAX_VAL 16'h0001
`define ID_CAPS_LBA_BIT 9
`define ID_CAPS_DMA_BIT 8
`define ID_PIO_OLD_VAL  16'h0200
`define ID_VALID_VAL    16'h0003
`define ID_MULT_VALID   16'h0100
`define ID_DMA_SUPPORT  8'h07
`define ID_PIO_ADV_VAL  16'h0003
`define ID_CYCLE_NS     16'h0050
`define ID_ADV_PIO_MAX  3'h2
`define ID_ADV_DMA_MAX  3'h2
`define ID_ADV_PCM_VAL  16'h001b
`define ID_SPACE        8'h20
`define ID_SER_CHARS    20
`define ID_MOD_CHARS    40
`define ID_FW_CHARS     8

`endif

// ===== core/ident_pkg.sv
/*
 * Types shared by the identify parameter block modules.
 * Assumes ident_map.svh sits on the include path.
 */
`include "ident_map.svh"

package ident_pkg;

    // Drive geometry as reported in a translation mode
    typedef struct packed {
        logic [15:0] cyl;
        logic [15:0] heads;
        logic [15:0] spt;
    } geom_t;

    // Mode settings chosen by the host through set-features
    typedef struct packed {
        logic [1:0] mwdma_sel;   // 0..2 standard mode, 3 none selected
        logic [2:0] adv_pio_sel;
        logic [2:0] adv_dma_sel;
        logic       mult_en;     // Current multiple count is 01h
        logic       dma_cap;
    } modes_t;

    // Transfer sequencer states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_FILL = 3'b010,
        ST_SEND = 3'b100
    } xfer_state_t;

endpackage

// ===== core/ident_text_pick.sv
/*
 * Picks one word of a fixed-width ASCII field, justified and padded with spaces.
 * Assumes character 0 of the text sits in bits 7:0 and the length is at most N.
 */
`timescale 1ns/1ns
`include "ident_map.svh"

module ident_text_pick #(
    parameter int N     = 20,
    parameter bit RIGHT = 1'b1
) (
    // Text source
    input  wire logic [8*N-1:0]         text,
    input  wire logic [$clog2(N+1)-1:0] len,
    // Word select within the field
    input  wire logic [7:0]             word_sel,
    output logic      [15:0]            word
);
    import ident_pkg::*;

    localparam int LW = $clog2(N+1);
    logic [8*N-1:0] field;

    // One character slot per field position
    genvar p;
    generate
        for (p = 0; p < N; p++) begin : g_slot
            localparam logic [LW-1:0] POS = LW'(p);
            localparam logic [LW-1:0] TOP = LW'(N);
            always_comb begin
                field[8*p +: 8] = `ID_SPACE;
                if (RIGHT) begin
                    // Text fills the tail, spaces lead
                    if (POS >= TOP - len)
                        field[8*p +: 8] = text[8*(p - N) + 8*len +: 8]; // R6
                end else if (POS < len) begin
                    field[8*p +: 8] = text[8*p +: 8]; // R7
                end
            end
        end
    endgenerate

    // First character of each pair goes in the upper byte
    always_comb begin
        word = 16'h0000;
        if (int'(word_sel) < N/2)
            word = {field[16*word_sel +: 8], field[16*word_sel + 8 +: 8]};
    end

endmodule

// ===== core/identify_block.sv
/*
 * Identify-drive parameter block source: builds the 256-word block and hands
 * it word by word to the data port with the same busy, data-request and
 * completion sequence that a one-sector read uses.
 * Assumes the command decoder pulses cmd_start for one cycle and that the
 * data port pulses data_rd once per word taken, both on sys_clk. The mode
 * pin ide_mode_pin comes straight from the card connector.
 * Mode words follow the filtered pin word by word, so a pin
 * change in mid-block shows from the next word on.
 */
`timescale 1ns/1ns
`include "ident_map.svh"

module identify_block #(
    // Arbitrary values; bit 6 of the alternate value marks non-removable
    // PCMCIA hosts expect the removable value
    parameter logic [15:0] CFG_WORD_PCMCIA = 16'h8001,
    parameter logic [15:0] CFG_WORD_IDE    = 16'h0041
) (
    // Clock and reset
    input  wire logic                     sys_clk,
    input  wire logic                     rstn,
    // Operating mode pin, high in true IDE mode
    input  wire logic                     ide_mode_pin,
    // Default and current geometry
    input  wire ident_pkg::geom_t         def_geom,
    input  wire ident_pkg::geom_t         cur_geom,
    // Capacity and host-selected modes
    input  wire logic [31:0]              sector_total,
    input  wire ident_pkg::modes_t        modes,
    // Serial text and its length
    input  wire logic [8*`ID_SER_CHARS-1:0] serial_text,
    input  wire logic [4:0]               serial_len,
    // Model and firmware text
    input  wire logic [8*`ID_MOD_CHARS-1:0] model_text,
    input  wire logic [5:0]               model_len,
    input  wire logic [8*`ID_FW_CHARS-1:0]  fw_text,
    // Command and data port
    input  wire logic                     cmd_start,
    input  wire logic                     data_rd,
    output logic                          xfer_busy,
    output logic                          xfer_drq,
    output logic      [15:0]              data_out,
    output logic                          xfer_done
);
    import ident_pkg::*;

    // Sequencer
    xfer_state_t state_r;
    xfer_state_t state_nxt;

    // Mode pin synchroniser
    logic [2:0]  ide_sync_r;
    logic        ide_r;

    // Word pointer and capacity
    logic [7:0]  idx_r;
    logic [7:0]  word_sel;
    logic [31:0] cur_cap_r;
    logic [47:0] cur_prod;

    // Word contents
    logic [15:0] word_val;
    logic [15:0] ser_word;
    logic [15:0] mod_word;

    // Data port registers
    logic [15:0] data_r;
    logic        done_r;

    // Decode helpers
    logic [7:0]  dma_onehot;
    logic        last_rd;

    // Mode pin crosses into sys_clk; a change counts once stages 2 and 3 agree
    // The pin is a static strap, so no handshake is needed
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            ide_sync_r <= 3'h0;
        end else begin
            ide_sync_r <= {ide_sync_r[1:0], ide_mode_pin};
        end
    end

    // Filtered mode level; reads PCMCIA after reset
    // Limitation: a pin change takes three to four cycles to show
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            ide_r <= 1'b0;
        end else if (ide_sync_r[2] == ide_sync_r[1]) begin
            ide_r <= ide_sync_r[2];
        end
    end

    // Read of the final word ends the transfer
    assign last_rd = (state_r == ST_SEND) && data_rd && (idx_r == `ID_LAST_WORD);

    // Sequencer: busy for one cycle, then data request until the last word
    // Idle: starts are taken only here; others drop
    // Fill: word 0 loads while busy shows
    // Send: each read moves one word on
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ST_IDLE: begin
                if (cmd_start)
                    state_nxt = ST_FILL; // R1
            end
            ST_FILL: begin
                // Busy lasts one cycle
                state_nxt = ST_SEND; // R1
            end
            ST_SEND: begin
                // Stay until the last word is taken
                if (last_rd)
                    state_nxt = ST_IDLE; // R22
            end
        endcase
    end

    // State register
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            state_r <= ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Word pointer walks upward one step per word taken
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            idx_r <= 8'h00;
        end else if (state_r == ST_FILL) begin
            // Restart under busy, before any read
            idx_r <= 8'h00;
        end else if (state_r == ST_SEND && data_rd) begin
            idx_r <= idx_r + 8'h01; // R22
        end
    end

    // The multiply is latched once per command so it stays off the word path
    // Only the low 32 bits are reported
    assign cur_prod = cur_geom.cyl * cur_geom.heads * cur_geom.spt;

    // Capacity, loaded as the start is taken
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            cur_cap_r <= 32'h0;
        end else if (state_r == ST_IDLE && cmd_start) begin
            cur_cap_r <= cur_prod[31:0]; // R12
        end
    end

    // Word to load next: word 0 on entry, else the one after the current
    // Decoding ahead allows a read every cycle
    assign word_sel = (state_r == ST_SEND) ? idx_r + 8'h01 : 8'h00;

    // Serial text, spaces lead
    ident_text_pick #(
        .N     (`ID_SER_CHARS),
        .RIGHT (1'b1)
    ) u_serial (
        .text     (serial_text),
        .len      (serial_len),
        .word_sel (word_sel - `ID_W_SER_FIRST),
        .word     (ser_word)
    );

    // Model text, spaces trail
    ident_text_pick #(
        .N     (`ID_MOD_CHARS),
        .RIGHT (1'b0)
    ) u_model (
        .text     (model_text),
        .len      (model_len),
        .word_sel (word_sel - `ID_W_MOD_FIRST),
        .word     (mod_word)
    );

    // One-hot code of the selected standard DMA mode, none when code 3
    // Higher modes show in word 163 only
    always_comb begin
        dma_onehot = 8'h00;
        if (modes.mwdma_sel != 2'h3)
            dma_onehot[modes.mwdma_sel] = 1'b1; // R14
    end

    // Word contents; every word not listed is reserved and reads zero
    always_comb begin
        word_val = 16'h0000; // R2
        case (word_sel) inside
            // Identity and default geometry
            `ID_W_CFG:
                word_val = ide_r ? CFG_WORD_IDE : CFG_WORD_PCMCIA; // R3
            `ID_W_DEF_CYL:
                word_val = def_geom.cyl; // R4
            `ID_W_DEF_HEAD:
                word_val = def_geom.heads;
            `ID_W_DEF_SPT:
                word_val = def_geom.spt;
            `ID_W_CAP_MSW:
                word_val = sector_total[31:16]; // R5
            `ID_W_CAP_LSW:
                word_val = sector_total[15:0]; // R5

            // Text, first character of a pair on top
            [`ID_W_SER_FIRST:`ID_W_SER_LAST]:
                word_val = ser_word; // R6
            `ID_W_RSV22:
                word_val = `ID_RSV22_VAL;
            [`ID_W_FW_FIRST:`ID_W_FW_LAST]:
                word_val = {fw_text[16*(word_sel - `ID_W_FW_FIRST) +: 8],
                            fw_text[16*(word_sel - `ID_W_FW_FIRST) + 8 +: 8]};
            [`ID_W_MOD_FIRST:`ID_W_MOD_LAST]:
                word_val = mod_word; // R7

            // Capabilities and validity flags
            `ID_W_MULT_MAX:
                word_val = `ID_MULT_MAX_VAL; // R8 R20
            `ID_W_CAPS: begin
                // Bit 13 stays zero: standby timer is maker defined
                word_val[`ID_CAPS_LBA_BIT] = 1'b1; // R9
                word_val[`ID_CAPS_DMA_BIT] = modes.dma_cap; // R9
            end
            `ID_W_PIO_OLD:
                word_val = `ID_PIO_OLD_VAL; // R10
            `ID_W_VALID:
                word_val = `ID_VALID_VAL; // R11

            // Current geometry and sector totals
            `ID_W_CUR_CYL:
                word_val = cur_geom.cyl;
            `ID_W_CUR_HEAD:
                word_val = cur_geom.heads;
            `ID_W_CUR_SPT:
                word_val = cur_geom.spt;
            `ID_W_CUR_LSW:
                word_val = cur_cap_r[15:0]; // R12
            `ID_W_CUR_MSW:
                word_val = cur_cap_r[31:16]; // R12
            `ID_W_MULT_SET:
                word_val = `ID_MULT_VALID | {15'h0, modes.mult_en}; // R13
            `ID_W_LBA_LSW:
                word_val = sector_total[15:0];
            `ID_W_LBA_MSW:
                word_val = sector_total[31:16];

            // DMA and cycle-time words
            `ID_W_DMA: begin
                // DMA is not offered in PCMCIA mode
                if (ide_r)
                    word_val = {dma_onehot, `ID_DMA_SUPPORT}; // R14 R15 R21
            end
            `ID_W_PIO_ADV:
                word_val = `ID_PIO_ADV_VAL; // R16
            `ID_W_DMA_MIN, `ID_W_DMA_REC: begin
                if (ide_r)
                    word_val = `ID_CYCLE_NS; // R17
            end
            `ID_W_PIO_MIN, `ID_W_PIO_IORDY:
                word_val = `ID_CYCLE_NS; // R17

            // Advanced timing words
            `ID_W_ADV_IDE:
                word_val = {4'h0, modes.adv_dma_sel, modes.adv_pio_sel,
                            `ID_ADV_DMA_MAX, `ID_ADV_PIO_MAX}; // R18 R19
            `ID_W_ADV_PCM:
                word_val = `ID_ADV_PCM_VAL;

            // Reserved, obsolete and maker words
            default:
                word_val = 16'h0000; // R2
        endcase
    end

    // Data register: loaded with word 0 while busy, then after each read
    // A flop keeps decode settling off the port
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            data_r <= 16'h0000;
        end else if (state_r == ST_FILL) begin
            data_r <= word_val; // R22
        end else if (state_r == ST_SEND && data_rd) begin
            // Past the last word the value is a don't-care, but held defined
            data_r <= last_rd ? 16'h0000 : word_val; // R22
        end
    end

    // Completion pulse after the final word, as a read raises its interrupt
    // A new start is taken from this cycle on
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            done_r <= 1'b0;
        end else begin
            done_r <= last_rd; // R1
        end
    end

    // Status outputs follow the sector-read sequence
    // Each compares all three one-hot state flops
    assign xfer_busy = (state_r == ST_FILL); // R1
    assign xfer_drq  = (state_r == ST_SEND); // R1
    assign data_out  = data_r;
    assign xfer_done = done_r;

endmodule

// ===== sim/ident_assertions.sv
/*
 * Port checker for identify_block: handshake timing, word count, fixed words.
 * Assumes it is bound to identify_block and sees only its ports.
 */
`timescale 1ns/1ns

module ident_assertions (
    // Clock and reset
    input wire logic        sys_clk,
    input wire logic        rstn,
    // Command and data port
    input wire logic        cmd_start,
    input wire logic        data_rd,
    input wire logic        xfer_busy,
    input wire logic        xfer_drq,
    input wire logic [15:0] data_out,
    input wire logic        xfer_done
);
    logic [8:0] idx_r;

    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    // Index of the word on data_out; busy restarts it so a refused start cannot
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn)
            idx_r <= 9'h000;
        else if (xfer_busy)
            idx_r <= 9'h000;
        else if (xfer_drq && data_rd)
            idx_r <= idx_r + 9'h001;
    end

    // Start seen in idle, then one busy cycle handing over to data request
    sequence s_start;
        !xfer_busy && !xfer_drq && cmd_start;
    endsequence
    sequence s_hand;
        xfer_busy ##1 (xfer_drq && !xfer_busy);
    endsequence

    property p_start;
        s_start |=> s_hand;
    endproperty
    property p_drq_src;
        $rose(xfer_drq) |-> $past(xfer_busy);
    endproperty
    property p_hold;
        xfer_drq && !data_rd |=> $stable(data_out) && xfer_drq;
    endproperty
    property p_count;
        xfer_done |-> idx_r == 9'h100 && !xfer_drq;
    endproperty
    property p_done;
        $fell(xfer_drq) |-> xfer_done ##1 !xfer_done;
    endproperty
    property p_w47;
        xfer_drq && idx_r == 9'h02f |-> data_out == 16'h0001;
    endproperty
    property p_w51;
        xfer_drq && idx_r == 9'h033 |-> data_out == 16'h0200;
    endproperty
    property p_w53;
        xfer_drq && idx_r == 9'h035 |-> data_out == 16'h0003;
    endproperty
    property p_w59;
        xfer_drq && idx_r == 9'h03b |-> data_out[15:8] == 8'h01 && data_out[7:1] == 7'h00;
    endproperty
    property p_w64;
        xfer_drq && idx_r == 9'h040 |-> data_out == 16'h0003;
    endproperty
    property p_w67;
        xfer_drq && (idx_r == 9'h043 || idx_r == 9'h044) |-> data_out == 16'h0050;
    endproperty

    a_start: assert property (p_start) else $error("start not answered");
    a_drq_src: assert property (p_drq_src) else $error("drq without busy");
    a_hold: assert property (p_hold) else $error("word moved unread");
    a_count: assert property (p_count) else $error("done before 256 words");
    a_done: assert property (p_done) else $error("bad done pulse");
    a_w47: assert property (p_w47) else $error("word 47 wrong");
    a_w51: assert property (p_w51) else $error("word 51 wrong");
    a_w53: assert property (p_w53) else $error("word 53 wrong");
    a_w59: assert property (p_w59) else $error("word 59 wrong");
    a_w64: assert property (p_w64) else $error("word 64 wrong");
    a_w67: assert property (p_w67) else $error("word 67 or 68 wrong");
endmodule

bind identify_block ident_assertions u_chk (
    .sys_clk(sys_clk), .rstn(rstn), .cmd_start(cmd_start), .data_rd(data_rd),
    .xfer_busy(xfer_busy), .xfer_drq(xfer_drq), .data_out(data_out),
    .xfer_done(xfer_done)
);

// ===== sim/host_model.sv
/*
 * Host side of the data port: issues the command pulse and reads words.
 * Assumes the bench calls run() with the card's other inputs settled.
 */
`timescale 1ns/1ns

module host_model (
    // Clock
    input  wire logic        sys_clk,
    // Data port from the card
    input  wire logic        xfer_drq,
    input  wire logic [15:0] data_out,
    input  wire logic        xfer_done,
    // Requests to the card
    output logic             cmd_start,
    output logic             data_rd
);
    logic [15:0] words [256];
    int          n_got;

    initial begin
        cmd_start = 1'b0;
        data_rd   = 1'b0;
    end

    // Read flow as for one sector; a larger stall makes a slower host
    task automatic run(input int stall, input int stop, input bit poke);
        int t;
        bit rd;
        n_got = 0;
        t = 0;
        rd = 1'b0;
        @(posedge sys_clk);
        #1 cmd_start = 1'b1;
        while (xfer_done !== 1'b1 && t < 4000 && (n_got < stop || rd)) begin
            @(posedge sys_clk);
            #1 t++;
            rd = xfer_drq === 1'b1 && n_got < stop && $urandom_range(stall, 0) == 0;
            if (rd) begin
                words[n_got] = data_out;
                n_got++;
            end
            data_rd = rd;
            // Stray start in mid-block, which the card must ignore
            cmd_start = poke && n_got == 100 && rd;
        end
    endtask
endmodule

// ===== sim/testbench.sv
/*
 * Testbench for identify_block: random drive data, whole-block reads
 * checked against a bench model, a refused start and a reset mid-block.
 * Assumes host_model drives the command and data port.
 */
`timescale 1ns/1ns

`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin num_errors++; \
    $display("BAD %0t got %h exp %h", $time, a, e); end end

module testbench;
    import ident_pkg::*;
    logic         sys_clk, rstn, ide_mode_pin, cmd_start, data_rd;
    logic         xfer_busy, xfer_drq, xfer_done;
    logic [15:0]  data_out;
    logic [31:0]  sector_total;
    geom_t        def_geom, cur_geom;
    modes_t       modes;
    logic [159:0] serial_text;
    logic [319:0] model_text;
    logic [63:0]  fw_text;
    logic [4:0]   serial_len;
    logic [5:0]   model_len;
    int           num_errors, n_compared, cycles;

    identify_block dut (
        .sys_clk(sys_clk), .rstn(rstn), .ide_mode_pin(ide_mode_pin),
        .def_geom(def_geom), .cur_geom(cur_geom), .sector_total(sector_total),
        .modes(modes), .serial_text(serial_text), .serial_len(serial_len),
        .model_text(model_text), .model_len(model_len), .fw_text(fw_text),
        .cmd_start(cmd_start), .data_rd(data_rd), .xfer_busy(xfer_busy),
        .xfer_drq(xfer_drq), .data_out(data_out), .xfer_done(xfer_done)
    );

    host_model host (
        .sys_clk(sys_clk), .xfer_drq(xfer_drq), .data_out(data_out),
        .xfer_done(xfer_done), .cmd_start(cmd_start), .data_rd(data_rd)
    );

    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    // Bench model of one character of the text fields
    function automatic logic [7:0] ch(input int f, input int p);
        int s;
        s = 20 - serial_len;
        if (f == 0)
            return p < s ? 8'h20 : serial_text[8*(p-s) +: 8];
        if (f == 1)
            return p < model_len ? model_text[8*p +: 8] : 8'h20;
        return fw_text[8*p +: 8];
    endfunction

    // Bench model of one word of the block
    function automatic logic [15:0] exp_word(input int i);
        logic [31:0] cap;
        logic [7:0]  oh;
        cap = cur_geom.cyl * cur_geom.heads * cur_geom.spt;
        oh = (modes.mwdma_sel == 2'h3) ? 8'h00 : 8'h01 << modes.mwdma_sel;
        if (i >= 10 && i <= 19)
            return {ch(0, 2*i-20), ch(0, 2*i-19)};
        if (i >= 23 && i <= 26)
            return {ch(2, 2*i-46), ch(2, 2*i-45)};
        if (i >= 27 && i <= 46)
            return {ch(1, 2*i-54), ch(1, 2*i-53)};
        case (i)
            0: return ide_mode_pin ? 16'h0041 : 16'h8001;
            1: return def_geom.cyl;
            3: return def_geom.heads;
            6: return def_geom.spt;
            7: return sector_total[31:16];
            8: return sector_total[15:0];
            22: return 16'h0004;
            47: return 16'h0001;
            49: return {6'h00, 1'b1, modes.dma_cap, 8'h00};
            51: return 16'h0200;
            53: return 16'h0003;
            54: return cur_geom.cyl;
            55: return cur_geom.heads;
            56: return cur_geom.spt;
            57: return cap[15:0];
            58: return cap[31:16];
            59: return {8'h01, 7'h00, modes.mult_en};
            60: return sector_total[15:0];
            61: return sector_total[31:16];
            63: return ide_mode_pin ? {oh, 8'h07} : 16'h0000;
            64: return 16'h0003;
            65, 66: return ide_mode_pin ? 16'h0050 : 16'h0000;
            67, 68: return 16'h0050;
            163: return {4'h0, modes.adv_dma_sel, modes.adv_pio_sel, 3'h2, 3'h2};
            164: return 16'h001b;
            default: return 16'h0000;
        endcase
    endfunction

    task automatic print_verdict();
        $display("Compared %0d, errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Hang guard, well above eight slow block reads
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            print_verdict();
        end
    end

    initial begin
        void'($urandom(32'h93a7));
        {rstn, ide_mode_pin, def_geom, cur_geom, sector_total, modes} = '0;
        {serial_text, model_text, fw_text, serial_len, model_len} = '0;
        repeat (12) @(posedge sys_clk);
        #1 rstn = 1'b1;
        `CHK({xfer_busy, xfer_drq, xfer_done, data_out}, 19'h0)
        for (int b = 0; b < 8; b++) begin
            @(posedge sys_clk);
            // Lengths hit both ends of the serial and model fields in the first blocks
            #1 ide_mode_pin = b[2];
            def_geom = 48'({$urandom, $urandom});
            cur_geom = 48'({$urandom, $urandom});
            sector_total = $urandom;
            modes = 10'($urandom);
            modes.mwdma_sel = b[1:0];
            for (int k = 0; k < 10; k++) begin
                model_text[32*k +: 32] = $urandom;
                if (k < 5)
                    serial_text[32*k +: 32] = $urandom;
                if (k < 2)
                    fw_text[32*k +: 32] = $urandom;
            end
            serial_len = b == 0 ? 5'h14 : b == 1 ? 5'h00 : 5'($urandom_range(20, 0));
            model_len = b == 0 ? 6'h28 : b == 1 ? 6'h00 : 6'($urandom_range(40, 0));
            // Mode pin passes a synchroniser, so let it settle first
            repeat (6) @(posedge sys_clk);
            if (b == 3) begin
                host.run(1, 60, 1'b0);
                rstn = 1'b0;
                repeat (2) @(posedge sys_clk);
                #1 rstn = 1'b1;
                `CHK({xfer_busy, xfer_drq, xfer_done, data_out}, 19'h0)
                repeat (6) @(posedge sys_clk);
            end
            host.run(b % 3, 256, b == 5);
            `CHK(host.n_got, 256)
            for (int i = 0; i < 256; i++)
                `CHK(host.words[i], exp_word(i))
        end
        print_verdict();
    end
endmodule
